// >>> dv/eer_host_model.sv
// Host-side model: software register accesses and datapath event strobes.
// Assumes one mclk; the bench calls these tasks right after rising edges.
`timescale 1ns/10ps
module eer_host_model (
  input wire logic mclk,
  output logic [12:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata,
  output eer_pkg::eer_src_t src
);
  initial begin
    reg_addr = 13'h0000;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    src = '0;
  end

  // ----------------------------------------------------------------
  // Register accesses
  // ----------------------------------------------------------------
  // Idle address and data show the inverse so stale values never match
  task automatic wr(input logic [12:0] a, input logic [31:0] d);
    logic [31:0] v;
    v = d;
    if (a == eer_pkg::EER_OFS_EVENT) begin
      v = d & eer_pkg::EER_EVENT_IMPL;
    end
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~v;
  endtask

  task automatic rd(input logic [12:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask

  // ----------------------------------------------------------------
  // Event strobes, one cycle each
  // ----------------------------------------------------------------
  task automatic pulse(input int k, input logic [10:0] len);
    eer_pkg::eer_src_t s;
    s = '0;
    s.rx_frame_len = len;
    s.tx_frame_len = len;
    case (k)
      0: s.hb_window_end = 1'b1;
      1: begin
        s.hb_window_end = 1'b1;
        s.hb_col_seen = 1'b1;
      end
      2: s.rx_frame_end = 1'b1;
      3: s.tx_frame_end = 1'b1;
      4: s.tx_paused = 1'b1;
      5: s.tx_last_bd = 1'b1;
      6: s.tx_bd_upd = 1'b1;
      7: s.rx_last_bd = 1'b1;
      8: s.rx_bd_upd = 1'b1;
      9: s.mgmt_done = 1'b1;
      10: s.bus_err = 1'b1;
      11: s.late_col = 1'b1;
      12: s.tx_attempt_col = 1'b1;
      13: s.tx_attempt_ok = 1'b1;
      default: s.tx_fifo_empty_mid = 1'b1;
    endcase
    @(posedge mclk);
    src <= s;
    s = '0;
    s.rx_frame_len = ~len;
    s.tx_frame_len = ~len;
    @(posedge mclk);
    src <= s;
  endtask
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the event register block.
// Assumes the host model drives the register port and event strobes.
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("mismatch at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module testbench;
  localparam logic [12:0] EV = eer_pkg::EER_OFS_EVENT;
  localparam logic [12:0] MK = eer_pkg::EER_OFS_MASK;
  localparam logic [12:0] CT = eer_pkg::EER_OFS_CTRL;
  localparam logic [12:0] TX = eer_pkg::EER_OFS_TXCTL;
  localparam logic [12:0] RX = eer_pkg::EER_OFS_RXCTL;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [12:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  eer_pkg::eer_src_t src;
  eer_pkg::eer_act_t act;
  logic ce;
  logic gs;
  logic pf;
  logic irq;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] d;

  always #2.5 mclk = ~mclk;

  eer_host_model u_eer_host_model (.mclk(mclk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .src(src));
  eer_event_reg u_eer_event_reg (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .src(src), .act_ff(act), .controller_enable_ff(ce),
    .graceful_stop_request_ff(gs), .pause_frame_transmit_request_ff(pf),
    .irq_ff(irq));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("counts: %0d compared, %0d mismatched", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Generous ceiling; the whole run needs well under 2000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      $display("mismatch at %0t: timeout", $time);
      print_verdict();
    end
  end

  task automatic wr(input logic [12:0] a, input logic [31:0] v);
    u_eer_host_model.wr(a, v);
  endtask

  task automatic rdc(input logic [12:0] a, input logic [31:0] e);
    u_eer_host_model.rd(a, d);
    `CHK(d, e)
  endtask

  task automatic ev(input int k, input logic [10:0] len);
    u_eer_host_model.pulse(k, len);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    rdc(EV, 32'h0000_0000);
    rdc(MK, 32'h0000_0000);
    rdc(RX, 32'h05ee_0000);
    rdc(13'h1000, 32'h0000_0000);
    wr(MK, 32'hffff_ffff);
    rdc(MK, 32'hfff8_0000);
    wr(MK, 32'h0000_0000);
    `CHK(irq, 1'b0)
    $display("test reset_values done");
  endtask

  task automatic t_normal_events();
    int ks[6] = '{4, 5, 6, 7, 8, 9};
    logic [31:0] ex[6] = '{32'h1000_0000, 32'h0c00_0000, 32'h0400_0000,
      32'h0200_0000, 32'h0100_0000, 32'h0080_0000};
    for (int i = 0; i < 6; i++) begin
      ev(ks[i], 11'h000);
      `CHK(irq, 1'b0)
      rdc(EV, ex[i]);
      wr(EV, 32'h0000_0000);
      rdc(EV, ex[i]);
      wr(MK, ex[i]);
      #1 `CHK(irq, 1'b1)
      wr(EV, ~ex[i]);
      #1 `CHK(irq, 1'b1)
      wr(MK, 32'h0000_0000);
      #1 `CHK(irq, 1'b0)
      wr(MK, ex[i]);
      wr(EV, ex[i]);
      #1 `CHK(irq, 1'b0)
      rdc(EV, 32'h0000_0000);
      wr(MK, 32'h0000_0000);
    end
    $display("test normal_events done");
  endtask

  task automatic t_babble();
    ev(2, 11'h5ee);
    rdc(EV, 32'h0000_0000);
    ev(2, 11'h5ef);
    ev(3, 11'h5ef);
    rdc(EV, 32'h6000_0000);
    rdc(eer_pkg::EER_OFS_CNT_RXBAB, 32'h0000_0001);
    rdc(eer_pkg::EER_OFS_CNT_TXBAB, 32'h0000_0001);
    wr(EV, 32'h6000_0000);
    $display("test babble done");
  endtask

  task automatic t_heartbeat();
    ev(0, 11'h000);
    rdc(EV, 32'h0000_0000);
    wr(TX, 32'h0000_000b);
    #1 `CHK({gs, pf}, 2'b11)
    ev(1, 11'h000);
    rdc(EV, 32'h0000_0000);
    ev(0, 11'h000);
    rdc(EV, 32'h8000_0000);
    rdc(eer_pkg::EER_OFS_CNT_HB, 32'h0000_0001);
    wr(EV, 32'h8000_0000);
    wr(TX, 32'h0000_0000);
    $display("test heartbeat done");
  endtask

  task automatic t_retry();
    wr(MK, 32'h0010_0000);
    repeat (15) ev(12, 11'h000);
    ev(13, 11'h000);
    repeat (15) ev(12, 11'h000);
    rdc(EV, 32'h0000_0000);
    ev(12, 11'h000);
    `CHK(act, 3'b011)
    `CHK(irq, 1'b1)
    rdc(EV, 32'h0010_0000);
    rdc(eer_pkg::EER_OFS_CNT_RL, 32'h0000_0001);
    wr(EV, 32'h0010_0000);
    wr(MK, 32'h0000_0000);
    $display("test retry done");
  endtask

  task automatic t_tx_errors();
    ev(11, 11'h000);
    `CHK(act, 3'b110)
    ev(14, 11'h000);
    `CHK(act, 3'b110)
    rdc(EV, 32'h0028_0000);
    rdc(eer_pkg::EER_OFS_CNT_LC, 32'h0000_0001);
    rdc(eer_pkg::EER_OFS_CNT_UN, 32'h0000_0001);
    wr(EV, 32'h0028_0000);
    wr(RX, 32'h05ee_0001);
    ev(11, 11'h000);
    rdc(EV, 32'h0000_0000);
    wr(RX, 32'h05ee_0000);
    $display("test tx_errors done");
  endtask

  task automatic t_bus_error();
    wr(CT, 32'h0000_0002);
    #1 `CHK(ce, 1'b1)
    ev(10, 11'h000);
    `CHK(ce, 1'b0)
    rdc(EV, 32'h0040_0000);
    wr(EV, 32'h0040_0000);
    // No fifo or dma soft-reset is modelled; software simply enables again
    wr(CT, 32'h0000_0002);
    #1 `CHK(ce, 1'b1)
    $display("test bus_error done");
  endtask

  task automatic t_mid_reset();
    wr(MK, 32'h0080_0000);
    ev(9, 11'h000);
    `CHK(irq, 1'b1)
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    #1 `CHK({irq, ce}, 2'b00)
    rdc(EV, 32'h0000_0000);
    rdc(MK, 32'h0000_0000);
    $display("test mid_reset done");
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset_values();
    t_normal_events();
    t_babble();
    t_heartbeat();
    t_retry();
    t_tx_errors();
    t_bus_error();
    t_mid_reset();
    print_verdict();
  end
endmodule

// >>> rtl/eer_counter.sv
// Saturating statistics counter bank, one counter per error class.
// Assumes one-cycle increment strobes and a synchronous reset.
`timescale 1ns/10ps
module eer_counter (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [eer_pkg::EER_NUM_CNT-1:0] inc,
  output logic [eer_pkg::EER_NUM_CNT*eer_pkg::EER_CNT_W-1:0] cnt_flat
);

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  // Saturate rather than wrap so management never sees a false low count
  genvar g;
  generate
    for (g = 0; g < eer_pkg::EER_NUM_CNT; g++) begin : g_cnt
      logic [eer_pkg::EER_CNT_W-1:0] cnt_ff;
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          cnt_ff <= '0;
        end else if (inc[g] && (cnt_ff != '1)) begin
          cnt_ff <= cnt_ff + 1'b1;
        end
      end
      assign cnt_flat[g*eer_pkg::EER_CNT_W +: eer_pkg::EER_CNT_W] = cnt_ff;
    end
  endgenerate

endmodule

// >>> rtl/eer_event_reg.sv
// Event flag register with mask, control bits and error counters.
// Assumes a one-cycle register port and datapath strobes on mclk.
`timescale 1ns/10ps

// How it works
// R1: An event bit raises the interrupt only when its mask bit is set.
// R2: Writing one clears an event bit; writing zero leaves it.
// R3: Reset clears every event bit.
// R4: Heartbeat error when checking enabled and no collision in window.
// R5: Receive babble when received frame exceeds maximum length.
// R6: Transmit babble when sent frame exceeds maximum; frame not truncated.
// R7: Graceful stop done once transmitter pauses after current frame.
// R8: Transmit frame bit after last descriptor of sent frame updated.
// R9: Transmit buffer bit on any transmit descriptor update.
// R10: Receive frame bit after last descriptor of received frame updated.
// R11: Receive buffer bit on non-final receive descriptor update.
// R12: Management transfer bit when transfer completes.
// R13: Bus error sets bit 22 and clears controller enable.
// R14: Software soft-resets FIFO and DMA after a bus error. No FIFO or DMA soft reset is modelled here.
// R15: Late collision in half duplex: bad CRC, discard remainder.
// R16: Sixteen collided attempts in half duplex: discard, start next.
// R17: Underrun: bad CRC appended, remainder discarded.
// R18: Software writes zeros to reserved bits 18 to 0.
// R19: Error classes also counted in statistics counters.
// R20: Interrupt stays until event cleared or mask cleared.
// R21: Sources sampled each clock regardless of mask.
// R22: Interrupt is OR of event AND mask over bits 31 to 19.
module eer_event_reg (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [12:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire eer_pkg::eer_src_t src,
  output eer_pkg::eer_act_t act_ff,
  output logic controller_enable_ff,
  output logic graceful_stop_request_ff,
  output logic pause_frame_transmit_request_ff,
  output logic irq_ff
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [31:0] event_ff;
  logic [31:0] mask_ff;
  logic [31:0] txctl_ff;
  logic [31:0] rxctl_ff;
  logic [31:0] nxt_event;
  logic [31:0] set_vec;
  logic [4:0] retry_ff;
  logic [eer_pkg::EER_NUM_CNT-1:0] cnt_inc;
  logic [eer_pkg::EER_NUM_CNT*eer_pkg::EER_CNT_W-1:0] cnt_flat;
  logic [10:0] max_frame_length;
  logic full_duplex;
  logic heartbeat_check_enable;
  logic wr_event;
  logic wr_mask;
  logic wr_ctrl;
  logic wr_txctl;
  logic wr_rxctl;
  logic hb_err;
  logic rx_bab;
  logic tx_bab;
  logic lc_err;
  logic rl_err;
  logic un_err;

  assign wr_event = reg_wr && (reg_addr == eer_pkg::EER_OFS_EVENT);
  assign wr_mask = reg_wr && (reg_addr == eer_pkg::EER_OFS_MASK);
  assign wr_ctrl = reg_wr && (reg_addr == eer_pkg::EER_OFS_CTRL);
  assign wr_txctl = reg_wr && (reg_addr == eer_pkg::EER_OFS_TXCTL);
  assign wr_rxctl = reg_wr && (reg_addr == eer_pkg::EER_OFS_RXCTL);
  assign max_frame_length = rxctl_ff[eer_pkg::EER_RX_MAXFL_LSB +: 11];
  assign full_duplex = rxctl_ff[eer_pkg::EER_RX_FDX_BIT];
  assign heartbeat_check_enable = txctl_ff[eer_pkg::EER_TX_HBC_BIT];

  // ----------------------------------------------------------------
  // Event detection
  // ----------------------------------------------------------------
  assign hb_err = heartbeat_check_enable && src.hb_window_end && !src.hb_col_seen; // R4
  assign rx_bab = src.rx_frame_end && (src.rx_frame_len > max_frame_length); // R5
  assign tx_bab = src.tx_frame_end && (src.tx_frame_len > max_frame_length); // R6
  assign lc_err = !full_duplex && src.late_col; // R15
  // Sixteenth consecutive collided attempt trips the limit
  assign rl_err = !full_duplex && src.tx_attempt_col
                  && (retry_ff == eer_pkg::EER_RETRY_LIMIT - 5'h01); // R16
  assign un_err = src.tx_fifo_empty_mid; // R17

  always_comb begin
    set_vec = '0;
    set_vec[eer_pkg::EER_BIT_HB] = hb_err;
    set_vec[eer_pkg::EER_BIT_RXBAB] = rx_bab;
    set_vec[eer_pkg::EER_BIT_TXBAB] = tx_bab;
    set_vec[eer_pkg::EER_BIT_GRA] = src.tx_paused; // R7
    set_vec[eer_pkg::EER_BIT_TXF] = src.tx_last_bd; // R8
    set_vec[eer_pkg::EER_BIT_TXB] = src.tx_bd_upd | src.tx_last_bd; // R9
    set_vec[eer_pkg::EER_BIT_RXF] = src.rx_last_bd; // R10
    set_vec[eer_pkg::EER_BIT_RXB] = src.rx_bd_upd && !src.rx_last_bd; // R11
    set_vec[eer_pkg::EER_BIT_MGMT] = src.mgmt_done; // R12
    set_vec[eer_pkg::EER_BIT_BUSERR] = src.bus_err; // R13
    set_vec[eer_pkg::EER_BIT_LC] = lc_err;
    set_vec[eer_pkg::EER_BIT_RL] = rl_err;
    set_vec[eer_pkg::EER_BIT_UN] = un_err;
  end

  // Set wins over a same-cycle clear so no event is lost
  always_comb begin
    nxt_event = event_ff;
    if (wr_event) begin
      nxt_event = event_ff & ~reg_wdata; // R2
    end
    nxt_event = (nxt_event | set_vec) & eer_pkg::EER_EVENT_IMPL; // R21
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      event_ff <= eer_pkg::EER_RST_EVENT; // R3
    end else begin
      event_ff <= nxt_event;
    end
  end

  // ----------------------------------------------------------------
  // Retry counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      retry_ff <= '0;
    end else if (src.tx_attempt_ok || rl_err) begin
      retry_ff <= '0;
    end else if (src.tx_attempt_col && !full_duplex) begin
      retry_ff <= retry_ff + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mask_ff <= eer_pkg::EER_RST_MASK;
    end else if (wr_mask) begin
      mask_ff <= reg_wdata & eer_pkg::EER_EVENT_IMPL;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      txctl_ff <= eer_pkg::EER_RST_TXCTL;
    end else if (wr_txctl) begin
      txctl_ff <= reg_wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rxctl_ff <= eer_pkg::EER_RST_RXCTL;
    end else if (wr_rxctl) begin
      rxctl_ff <= reg_wdata;
    end
  end

  // Bus error beats a same-cycle software enable
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      controller_enable_ff <= eer_pkg::EER_RST_CTRL[eer_pkg::EER_CTRL_EN_BIT];
    end else if (src.bus_err) begin
      controller_enable_ff <= 1'b0; // R13
    end else if (wr_ctrl) begin
      controller_enable_ff <= reg_wdata[eer_pkg::EER_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      graceful_stop_request_ff <= 1'b0;
      pause_frame_transmit_request_ff <= 1'b0;
    end else begin
      graceful_stop_request_ff <= nxt_gts();
      pause_frame_transmit_request_ff <= nxt_pause();
    end
  end

  function automatic logic nxt_gts();
    nxt_gts = wr_txctl ? reg_wdata[eer_pkg::EER_TX_GTS_BIT]
                       : txctl_ff[eer_pkg::EER_TX_GTS_BIT];
  endfunction

  function automatic logic nxt_pause();
    nxt_pause = wr_txctl ? reg_wdata[eer_pkg::EER_TX_PAUSE_BIT]
                         : txctl_ff[eer_pkg::EER_TX_PAUSE_BIT];
  endfunction

  // ----------------------------------------------------------------
  // Datapath actions
  // ----------------------------------------------------------------
  // Babble raises no action: long frames are sent whole
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      act_ff <= '0;
    end else begin
      act_ff.bad_crc_end <= lc_err | un_err; // R15 R17
      act_ff.discard_frame <= lc_err | rl_err | un_err; // R16
      act_ff.next_frame <= rl_err; // R16
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_event & (wr_mask ? reg_wdata : mask_ff)
                  & eer_pkg::EER_EVENT_IMPL); // R1 R20 R22
    end
  end

  // ----------------------------------------------------------------
  // Statistics counters
  // ----------------------------------------------------------------
  assign cnt_inc = {un_err, rl_err, lc_err, tx_bab, rx_bab, hb_err}; // R19

  eer_counter u_cnt (
    .mclk(mclk),
    .rst_n(rst_n),
    .inc(cnt_inc),
    .cnt_flat(cnt_flat)
  );

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Unmapped addresses read zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        eer_pkg::EER_OFS_EVENT: reg_rdata <= event_ff;
        eer_pkg::EER_OFS_MASK: reg_rdata <= mask_ff;
        eer_pkg::EER_OFS_CTRL: reg_rdata <= {30'h0, controller_enable_ff, 1'b0};
        eer_pkg::EER_OFS_TXCTL: reg_rdata <= txctl_ff;
        eer_pkg::EER_OFS_RXCTL: reg_rdata <= rxctl_ff;
        eer_pkg::EER_OFS_CNT_HB: reg_rdata <= {16'h0, cnt_flat[15:0]};
        eer_pkg::EER_OFS_CNT_RXBAB: reg_rdata <= {16'h0, cnt_flat[31:16]};
        eer_pkg::EER_OFS_CNT_TXBAB: reg_rdata <= {16'h0, cnt_flat[47:32]};
        eer_pkg::EER_OFS_CNT_LC: reg_rdata <= {16'h0, cnt_flat[63:48]};
        eer_pkg::EER_OFS_CNT_RL: reg_rdata <= {16'h0, cnt_flat[79:64]};
        eer_pkg::EER_OFS_CNT_UN: reg_rdata <= {16'h0, cnt_flat[95:80]};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  irq_follows_mask_a: assert property (@(posedge mclk) disable iff (!rst_n) // R1
    irq_ff == |($past(nxt_event) & $past(wr_mask ? reg_wdata : mask_ff)))
    else $error("irq does not follow masked events");
  w1c_clears_a: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    wr_event && reg_wdata[eer_pkg::EER_BIT_MGMT] && !src.mgmt_done
    |=> !event_ff[eer_pkg::EER_BIT_MGMT])
    else $error("write one did not clear event");
  w0_keeps_a: assert property (@(posedge mclk) disable iff (!rst_n) // R2
    wr_event && !reg_wdata[eer_pkg::EER_BIT_GRA] && event_ff[eer_pkg::EER_BIT_GRA]
    |=> event_ff[eer_pkg::EER_BIT_GRA])
    else $error("write zero changed event");
  reset_clears_a: assert property (@(posedge mclk) // R3
    !rst_n |=> event_ff == '0 && !irq_ff)
    else $error("reset left event bits set");
  heartbeat_set_a: assert property (@(posedge mclk) disable iff (!rst_n) // R4
    heartbeat_check_enable && src.hb_window_end && !src.hb_col_seen
    |=> event_ff[eer_pkg::EER_BIT_HB])
    else $error("heartbeat error missed");
  rx_babble_a: assert property (@(posedge mclk) disable iff (!rst_n) // R5
    src.rx_frame_end && src.rx_frame_len > max_frame_length
    |=> event_ff[eer_pkg::EER_BIT_RXBAB])
    else $error("receive babble missed");
  bus_error_a: assert property (@(posedge mclk) disable iff (!rst_n) // R13
    src.bus_err |=> !controller_enable_ff && event_ff[eer_pkg::EER_BIT_BUSERR])
    else $error("bus error did not halt controller");
  retry_limit_a: assert property (@(posedge mclk) disable iff (!rst_n) // R16
    rl_err |=> act_ff.next_frame && act_ff.discard_frame && retry_ff == 5'h00)
    else $error("retry limit action wrong");
  reserved_zero_a: assert property (@(posedge mclk) disable iff (!rst_n) // R18
    event_ff[18:0] == 19'h0)
    else $error("reserved event bits set");
  // Event bits trail their strobes by one edge; a set beats a same-cycle clear
  heartbeat_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n) // R4
    src.hb_window_end && src.hb_col_seen && !event_ff[eer_pkg::EER_BIT_HB]
    |=> !event_ff[eer_pkg::EER_BIT_HB])
    else $error("heartbeat error despite collision");
  tx_babble_a: assert property (@(posedge mclk) disable iff (!rst_n) // R6
    src.tx_frame_end && src.tx_frame_len > max_frame_length
    |=> event_ff[eer_pkg::EER_BIT_TXBAB])
    else $error("transmit babble missed");
  graceful_stop_a: assert property (@(posedge mclk) disable iff (!rst_n) // R7
    src.tx_paused
    |=> event_ff[eer_pkg::EER_BIT_GRA])
    else $error("graceful stop event missed");
  tx_frame_a: assert property (@(posedge mclk) disable iff (!rst_n) // R8
    src.tx_last_bd
    |=> event_ff[eer_pkg::EER_BIT_TXF] && event_ff[eer_pkg::EER_BIT_TXB])
    else $error("transmit frame event missed");
  tx_buffer_a: assert property (@(posedge mclk) disable iff (!rst_n) // R9
    src.tx_bd_upd
    |=> event_ff[eer_pkg::EER_BIT_TXB])
    else $error("transmit buffer event missed");
  rx_frame_a: assert property (@(posedge mclk) disable iff (!rst_n) // R10
    src.rx_last_bd
    |=> event_ff[eer_pkg::EER_BIT_RXF])
    else $error("receive frame event missed");
  rx_buffer_a: assert property (@(posedge mclk) disable iff (!rst_n) // R11
    src.rx_bd_upd && !src.rx_last_bd
    |=> event_ff[eer_pkg::EER_BIT_RXB])
    else $error("receive buffer event missed");
  mgmt_done_a: assert property (@(posedge mclk) disable iff (!rst_n) // R12
    src.mgmt_done
    |=> event_ff[eer_pkg::EER_BIT_MGMT])
    else $error("management event missed");
  late_collision_a: assert property (@(posedge mclk) disable iff (!rst_n) // R15
    !full_duplex && src.late_col
    |=> event_ff[eer_pkg::EER_BIT_LC] && act_ff.bad_crc_end && act_ff.discard_frame)
    else $error("late collision handling wrong");
  duplex_quiet_a: assert property (@(posedge mclk) disable iff (!rst_n) // R15
    full_duplex && src.late_col && !event_ff[eer_pkg::EER_BIT_LC]
    |=> !event_ff[eer_pkg::EER_BIT_LC])
    else $error("late collision flagged in full duplex");
  underrun_a: assert property (@(posedge mclk) disable iff (!rst_n) // R17
    src.tx_fifo_empty_mid
    |=> event_ff[eer_pkg::EER_BIT_UN] && act_ff.bad_crc_end && act_ff.discard_frame)
    else $error("underrun handling wrong");
  irq_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // R20
    irq_ff && !wr_event && !wr_mask
    |=> irq_ff)
    else $error("irq dropped without a clear");

endmodule

// >>> rtl/eer_pkg.sv
// Package for the ethernet event register block: offsets, bit positions,
// reset values and the event carrier struct.
// Assumes a 32-bit register port with byte offsets as printed.
package eer_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [12:0] EER_OFS_EVENT = 13'h1004;
  localparam logic [12:0] EER_OFS_MASK = 13'h1008;
  localparam logic [12:0] EER_OFS_CTRL = 13'h1024;
  localparam logic [12:0] EER_OFS_TXCTL = 13'h10c4;
  localparam logic [12:0] EER_OFS_RXCTL = 13'h1084;
  localparam logic [12:0] EER_OFS_CNT_HB = 13'h126c;
  localparam logic [12:0] EER_OFS_CNT_RXBAB = 13'h1298;
  localparam logic [12:0] EER_OFS_CNT_TXBAB = 13'h1218;
  localparam logic [12:0] EER_OFS_CNT_LC = 13'h125c;
  localparam logic [12:0] EER_OFS_CNT_RL = 13'h1260;
  localparam logic [12:0] EER_OFS_CNT_UN = 13'h1264;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int EER_BIT_HB = 31;
  localparam int EER_BIT_RXBAB = 30;
  localparam int EER_BIT_TXBAB = 29;
  localparam int EER_BIT_GRA = 28;
  localparam int EER_BIT_TXF = 27;
  localparam int EER_BIT_TXB = 26;
  localparam int EER_BIT_RXF = 25;
  localparam int EER_BIT_RXB = 24;
  localparam int EER_BIT_MGMT = 23;
  localparam int EER_BIT_BUSERR = 22;
  localparam int EER_BIT_LC = 21;
  localparam int EER_BIT_RL = 20;
  localparam int EER_BIT_UN = 19;
  localparam int EER_NUM_EV = 13;
  localparam int EER_CTRL_EN_BIT = 1;
  localparam int EER_TX_HBC_BIT = 1;
  localparam int EER_TX_GTS_BIT = 0;
  localparam int EER_TX_PAUSE_BIT = 3;
  localparam int EER_RX_FDX_BIT = 0;
  localparam int EER_RX_MAXFL_LSB = 16;
  localparam int EER_NUM_CNT = 6;
  localparam int EER_CNT_W = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] EER_RST_EVENT = 32'h0000_0000;
  localparam logic [31:0] EER_RST_MASK = 32'h0000_0000;
  localparam logic [31:0] EER_RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] EER_RST_TXCTL = 32'h0000_0000;
  localparam logic [31:0] EER_RST_RXCTL = 32'h05ee_0000;
  localparam logic [31:0] EER_EVENT_IMPL = 32'hfff8_0000;
  localparam logic [10:0] EER_MAXFL_RST = 11'h5ee;
  localparam logic [4:0] EER_RETRY_LIMIT = 5'h10;

  // ----------------------------------------------------------------
  // Event strobes from the controller datapath, one cycle each
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hb_window_end;
    logic hb_col_seen;
    logic rx_frame_end;
    logic [10:0] rx_frame_len;
    logic tx_frame_end;
    logic [10:0] tx_frame_len;
    logic tx_paused;
    logic tx_last_bd;
    logic tx_bd_upd;
    logic rx_last_bd;
    logic rx_bd_upd;
    logic mgmt_done;
    logic bus_err;
    logic late_col;
    logic tx_attempt_col;
    logic tx_attempt_ok;
    logic tx_fifo_empty_mid;
  } eer_src_t;

  // Actions requested of the datapath
  typedef struct packed {
    logic bad_crc_end;
    logic discard_frame;
    logic next_frame;
  } eer_act_t;

endpackage
